// ==== bnac_defines.vh ====
/*
 * Constants for the boot node address and connection window loader:
 * register offsets, field positions, reset values, flash layout, timing.
 * Assumes inclusion by bare name from the design, checker, flash model and bench files.
 */
`ifndef BNAC_DEFINES_VH
`define BNAC_DEFINES_VH

// Register byte offsets
`define BNAC_OFS_LINK_CTRL     4'h0
`define BNAC_OFS_BOOT_STATUS   4'h4
`define BNAC_OFS_NVM_BYTES     4'h8

// Link control fields
`define BNAC_SLOPE_HI          12
`define BNAC_SLOPE_LO          11
`define BNAC_HIRATE_BIT        0
`define BNAC_SLOPE_FLASH       2'h3
`define BNAC_LINK_CTRL_RST     32'h00000000
`define BNAC_LINK_CTRL_MASK    32'h00001801

// Node address values
`define BNAC_NODE_ADDR_ZERO    8'h00
`define BNAC_NODE_ADDR_DEF     8'h7f
`define BNAC_NODE_ADDR_BCAST   8'hff

// Window byte fields and codes
`define BNAC_WIN_VAL_HI        5
`define BNAC_WIN_IF_BIT        7
`define BNAC_WIN_SKIP          6'h01
`define BNAC_WIN_MIN           6'h02
`define BNAC_WIN_MAX           6'h0c

// Flash layout
`define BNAC_FLASH_BASE        32'h11000000
`define BNAC_WIN_OFS           32'h00001004
`define BNAC_NODE_OFS          32'h00001002
`define BNAC_FLASH_SIZE_DEF    32'h0001f000

// Timing: window step in ms, clock in kHz, baud in tenths of kBaud
`define BNAC_STEP_MS           32'h00000005
`define BNAC_CLK_KHZ           32'h0003d090
`define BNAC_HIRATE_BAUD_DK    16'h0480

// AXI responses
`define BNAC_RESP_OKAY         2'h0
`define BNAC_RESP_DECERR       2'h3

`endif

// ==== bnac_axil_slv.v ====
/*
 * AXI4-Lite slave front end for the loader registers.
 * Assumes a register file that accepts a one-cycle write strobe and
 * answers a read address combinationally.
 */
`timescale 1ns/1ps
`include "bnac_defines.vh"

module bnac_axil_slv (
   input  wire        aclk,
   input  wire        aresetn,
   input  wire [3:0]  s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output wire        s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output wire        s_axi_wready,
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   input  wire [3:0]  s_axi_araddr,
   input  wire        s_axi_arvalid,
   output wire        s_axi_arready,
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   output wire        wr_en,
   output wire [3:0]  wr_addr,
   output wire [31:0] wr_data,
   output wire [3:0]  wr_strb,
   input  wire        wr_hit,
   output wire [3:0]  rd_addr,
   input  wire [31:0] rd_data,
   input  wire        rd_hit
);
   reg        aw_full_q;
   reg [3:0]  aw_addr_q;
   reg        w_full_q;
   reg [31:0] w_data_q;
   reg [3:0]  w_strb_q;

   // Each channel holds one beat; no new beat until the response drains
   assign s_axi_awready = !aw_full_q && !s_axi_bvalid;
   assign s_axi_wready  = !w_full_q && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;
   assign wr_en   = aw_full_q && w_full_q && !s_axi_bvalid;
   assign wr_addr = aw_addr_q;
   assign wr_data = w_data_q;
   assign wr_strb = w_strb_q;
   assign rd_addr = s_axi_araddr;

   // Write path: address and data in either order
   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_full_q    <= 1'b0;
         aw_addr_q    <= 4'h0;
         w_full_q     <= 1'b0;
         w_data_q     <= 32'h00000000;
         w_strb_q     <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `BNAC_RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_full_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_full_q <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
         end
         if (wr_en) begin
            aw_full_q    <= 1'b0;
            w_full_q     <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? `BNAC_RESP_OKAY : `BNAC_RESP_DECERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Read path: data captured at the address handshake
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h00000000;
         s_axi_rresp  <= `BNAC_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= rd_hit ? rd_data : 32'h00000000;
         s_axi_rresp  <= rd_hit ? `BNAC_RESP_OKAY : `BNAC_RESP_DECERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end
endmodule // bnac_axil_slv

// ==== bnac_boot_cfg.v ====
/*
 * Boot configuration loader: fetches the window and node address bytes
 * with their complements from flash, picks the effective node address,
 * runs the boot connection window and sets up the serial link.
 * Assumes a byte-wide flash read port with a request/acknowledge pair and
 * a link receiver that presents each addressed request's node address.
 */
// Added by the designer: the placing of the registers and the AXI4-Lite slave port.

// Operation
// RULE_01 - Node address is one byte, zero illegal
// RULE_02 - Stored zero address falls back to 0x7F
// RULE_03 - Broadcast 0xFF is always accepted
// RULE_04 - Address complement mismatch falls back to 0x7F
// RULE_05 - Address byte at base plus size minus 0x1002
// RULE_06 - Window 0x02..0x0C selects high-rate link at 115.2k
// RULE_07 - High-rate boot writes slope field to 0b11
// RULE_08 - Window expiry without connection starts user program
// RULE_09 - Boot slope setting persists until software rewrites
// RULE_10 - Window bits 5:0 give 5 ms timeout steps
// RULE_11 - Window byte needs matching complement, else waits forever
// RULE_12 - Window bit 7 selects boot interface
// RULE_13 - Checks done once after reset, results held
`timescale 1ns/1ps
`include "bnac_defines.vh"

module bnac_boot_cfg #(
   parameter [31:0] FLASH_SIZE = `BNAC_FLASH_SIZE_DEF,
   parameter [31:0] STEP_CYC   = `BNAC_STEP_MS * `BNAC_CLK_KHZ
) (
   input  wire        aclk,
   input  wire        aresetn,
   // Register bus
   input  wire [3:0]  s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output wire        s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output wire        s_axi_wready,
   output wire [1:0]  s_axi_bresp,
   output wire        s_axi_bvalid,
   input  wire        s_axi_bready,
   input  wire [3:0]  s_axi_araddr,
   input  wire        s_axi_arvalid,
   output wire        s_axi_arready,
   output wire [31:0] s_axi_rdata,
   output wire [1:0]  s_axi_rresp,
   output wire        s_axi_rvalid,
   input  wire        s_axi_rready,
   // Flash byte read port
   output reg         nvm_rd_req,
   output reg  [31:0] nvm_rd_addr,
   input  wire        nvm_rd_ack,
   input  wire [7:0]  nvm_rd_data,
   // Link side
   input  wire [7:0]  req_node_address,
   output wire        node_address_match,
   input  wire        boot_conn_open,
   output reg  [7:0]  node_address,
   output reg         boot_window_open,
   output reg         user_start,
   output reg         user_mode,
   output reg         boot_if_uart,
   output reg  [15:0] high_rate_baud,
   output wire        high_rate_boot_protocol,
   output wire [1:0]  slope_mode_field
);
   // Loader states; boot and user are terminal until reset
   localparam [2:0] ST_FETCH  = 3'h0;
   localparam [2:0] ST_WAIT   = 3'h1;
   localparam [2:0] ST_EVAL   = 3'h2;
   localparam [2:0] ST_WINDOW = 3'h3;
   localparam [2:0] ST_BOOT   = 3'h4;
   localparam [2:0] ST_USER   = 3'h5;

   // Flash byte addresses of the window pair and the address pair
   localparam [31:0] WIN_ADDR = `BNAC_FLASH_BASE + FLASH_SIZE - `BNAC_WIN_OFS;
   localparam [31:0] NODE_ADDR = `BNAC_FLASH_BASE + FLASH_SIZE - `BNAC_NODE_OFS;

   // Sequencer, held boot results and window timer
   reg [2:0]  state_q;
   reg [1:0]  idx_q;
   reg [31:0] link_ctrl_q;
   reg        win_valid_q;
   reg        node_valid_q;
   reg        forever_q;
   reg [5:0]  steps_q;
   reg [31:0] tick_q;

   // Bus side nets and decoded flash bytes
   wire        wr_en;
   wire [3:0]  wr_addr;
   wire [31:0] wr_data;
   wire [3:0]  wr_strb;
   wire [3:0]  rd_addr;
   reg  [31:0] rd_data;
   reg         rd_hit;
   wire        wr_hit;
   wire        boot_slope_set;
   wire [31:0] wr_mask;
   wire [7:0]  win_byte;
   wire [7:0]  win_inv;
   wire [7:0]  node_byte;
   wire [7:0]  node_inv;
   wire [5:0]  win_val;
   wire        win_ok;
   wire        node_ok;
   wire        hirate_sel;
   wire [7:0]  nvm_byte [0:3];
   wire [3:0]  byte_load;
   wire [3:0]  idx_dec;
   wire [31:0] status_word;

   bnac_axil_slv u_axil (
      .aclk          (aclk),
      .aresetn       (aresetn),
      .s_axi_awaddr  (s_axi_awaddr),
      .s_axi_awvalid (s_axi_awvalid),
      .s_axi_awready (s_axi_awready),
      .s_axi_wdata   (s_axi_wdata),
      .s_axi_wstrb   (s_axi_wstrb),
      .s_axi_wvalid  (s_axi_wvalid),
      .s_axi_wready  (s_axi_wready),
      .s_axi_bresp   (s_axi_bresp),
      .s_axi_bvalid  (s_axi_bvalid),
      .s_axi_bready  (s_axi_bready),
      .s_axi_araddr  (s_axi_araddr),
      .s_axi_arvalid (s_axi_arvalid),
      .s_axi_arready (s_axi_arready),
      .s_axi_rdata   (s_axi_rdata),
      .s_axi_rresp   (s_axi_rresp),
      .s_axi_rvalid  (s_axi_rvalid),
      .s_axi_rready  (s_axi_rready),
      .wr_en         (wr_en),
      .wr_addr       (wr_addr),
      .wr_data       (wr_data),
      .wr_strb       (wr_strb),
      .wr_hit        (wr_hit),
      .rd_addr       (rd_addr),
      .rd_data       (rd_data),
      .rd_hit        (rd_hit)
   );

   // One capture register per fetched byte, loaded on its own acknowledge
   assign idx_dec = 4'h1 << idx_q;
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi = gi + 1) begin : g_byte
         reg [7:0] byte_q;
         // Loaded once per reset; the fetch never revisits an entry
         always @(posedge aclk) begin
            if (!aresetn) begin
               byte_q <= 8'h00;
            end else if (byte_load[gi]) begin
               byte_q <= nvm_rd_data;
            end
         end
         assign byte_load[gi] = (state_q == ST_WAIT) && nvm_rd_ack && idx_dec[gi];
         assign nvm_byte[gi]  = byte_q;
      end
   endgenerate

   // Bytes in fetch order: window, its complement, address, its complement
   assign win_byte  = nvm_byte[0];
   assign win_inv   = nvm_byte[1];
   assign node_byte = nvm_byte[2];
   assign node_inv  = nvm_byte[3];
   assign win_val   = win_byte[`BNAC_WIN_VAL_HI:0];          // [RULE_10]
   assign win_ok    = (~win_byte == win_inv);                // [RULE_11]
   assign node_ok   = (~node_byte == node_inv);              // [RULE_04]
   assign hirate_sel = win_ok && (win_val >= `BNAC_WIN_MIN) &&
                       (win_val <= `BNAC_WIN_MAX);           // [RULE_06]
   assign boot_slope_set = (state_q == ST_EVAL) && hirate_sel;

   // Broadcast bypasses the stored address entirely
   assign node_address_match = (req_node_address == `BNAC_NODE_ADDR_BCAST) ||
                               (req_node_address == node_address); // [RULE_03]

   assign high_rate_boot_protocol = link_ctrl_q[`BNAC_HIRATE_BIT];
   assign slope_mode_field = link_ctrl_q[`BNAC_SLOPE_HI:`BNAC_SLOPE_LO];

   // Byte-lane mask for software writes
   assign wr_mask = {{8{wr_strb[3]}}, {8{wr_strb[2]}}, {8{wr_strb[1]}}, {8{wr_strb[0]}}};
   assign wr_hit  = (wr_addr == `BNAC_OFS_LINK_CTRL);

   // Status word: held boot results, unused bits read as zero
   assign status_word = {8'h00, win_val, forever_q, boot_if_uart, node_address,
                         2'h0, node_valid_q, win_valid_q, user_mode, state_q};

   // Read decode; status shows the held boot results
   always @* begin
      rd_hit  = 1'b1;
      rd_data = 32'h00000000;
      case (rd_addr)
         `BNAC_OFS_LINK_CTRL:   rd_data = link_ctrl_q;
         `BNAC_OFS_BOOT_STATUS: rd_data = status_word;
         `BNAC_OFS_NVM_BYTES:   rd_data = {node_inv, node_byte, win_inv, win_byte};
         default:               rd_hit  = 1'b0;
      endcase
   end

   // Link control: boot load sets it once, software owns it afterwards
   always @(posedge aclk) begin
      if (!aresetn) begin
         link_ctrl_q <= `BNAC_LINK_CTRL_RST;
      end else if (boot_slope_set) begin
         link_ctrl_q[`BNAC_SLOPE_HI:`BNAC_SLOPE_LO] <= `BNAC_SLOPE_FLASH; // [RULE_07]
         link_ctrl_q[`BNAC_HIRATE_BIT] <= 1'b1;                          // [RULE_06]
      end else if (wr_en && wr_hit) begin
         // Not touched on entry to user mode, so the boot slope stays
         link_ctrl_q <= ((link_ctrl_q & ~wr_mask) | (wr_data & wr_mask)) &
                        `BNAC_LINK_CTRL_MASK;                            // [RULE_09]
      end
   end

   // Fetch, evaluate once, then run the window
   always @(posedge aclk) begin
      if (!aresetn) begin
         state_q          <= ST_FETCH;
         idx_q            <= 2'h0;
         nvm_rd_req       <= 1'b0;
         nvm_rd_addr      <= 32'h00000000;
         node_address     <= `BNAC_NODE_ADDR_DEF;
         win_valid_q      <= 1'b0;
         node_valid_q     <= 1'b0;
         forever_q        <= 1'b0;
         boot_if_uart     <= 1'b0;
         high_rate_baud   <= 16'h0000;
         steps_q          <= 6'h00;
         tick_q           <= 32'h00000000;
         boot_window_open <= 1'b0;
         user_start       <= 1'b0;
         user_mode        <= 1'b0;
      end else begin
         user_start <= 1'b0;
         case (state_q)
            ST_FETCH: begin
               nvm_rd_req <= 1'b1;
               // Window pair first, then the address pair
               nvm_rd_addr <= idx_q[1] ? (NODE_ADDR + {31'h0, idx_q[0]})
                                       : (WIN_ADDR + {31'h0, idx_q[0]});   // [RULE_05]
               state_q <= ST_WAIT;
            end
            ST_WAIT: begin
               if (nvm_rd_ack) begin
                  nvm_rd_req <= 1'b0;
                  idx_q <= idx_q + 2'h1;
                  state_q <= (idx_q == 2'h3) ? ST_EVAL : ST_FETCH;
               end
            end
            ST_EVAL: begin
               // Results latched here and never re-evaluated
               win_valid_q  <= win_ok;                                     // [RULE_13]
               node_valid_q <= node_ok;
               if (node_ok && node_byte != `BNAC_NODE_ADDR_ZERO) begin     // [RULE_01]
                  node_address <= node_byte;
               end else begin
                  node_address <= `BNAC_NODE_ADDR_DEF;                     // [RULE_02] [RULE_04]
               end
               // Erased flash fails the check and picks the LIN variant
               boot_if_uart <= win_ok && win_byte[`BNAC_WIN_IF_BIT];        // [RULE_12]
               high_rate_baud <= hirate_sel ? `BNAC_HIRATE_BAUD_DK : 16'h0000;
               steps_q <= win_val - 6'h01;                                 // [RULE_10]
               tick_q  <= 32'h00000000;
               if (win_ok && win_val == `BNAC_WIN_SKIP) begin
                  user_start <= 1'b1;
                  user_mode  <= 1'b1;
                  state_q    <= ST_USER;
               end else begin
                  forever_q        <= !hirate_sel;                         // [RULE_11]
                  boot_window_open <= 1'b1;
                  state_q          <= ST_WINDOW;
               end
            end
            ST_WINDOW: begin
               if (boot_conn_open) begin
                  boot_window_open <= 1'b0;
                  state_q <= ST_BOOT;
               end else if (!forever_q) begin
                  if (tick_q == STEP_CYC - 32'h1) begin
                     tick_q  <= 32'h00000000;
                     steps_q <= steps_q - 6'h01;
                     // Zero steps left: window over, hand to user code
                     if (steps_q == 6'h01) begin
                        boot_window_open <= 1'b0;
                        user_start <= 1'b1;                                // [RULE_08]
                        user_mode  <= 1'b1;
                        state_q    <= ST_USER;
                     end
                  end else begin
                     tick_q <= tick_q + 32'h1;
                  end
               end
            end
            ST_BOOT: begin
               // Host owns the link now; only reset leaves
               state_q <= ST_BOOT;
            end
            ST_USER: begin
               // User code runs; loaded results stay held
               state_q <= ST_USER;                                         // [RULE_13]
            end
            default: state_q <= ST_FETCH;
         endcase
      end
   end
endmodule // bnac_boot_cfg

// ==== bnac_boot_cfg_monitor.sv ====
/* Checker for the boot configuration loader ports.
   Assumes the bind below and the shared defines header. */
`timescale 1ns/1ps
`include "bnac_defines.vh"
module bnac_boot_cfg_monitor #(
   parameter [31:0] FLASH_SIZE = `BNAC_FLASH_SIZE_DEF
) (
   input wire        aclk,
   input wire        aresetn,
   input wire        s_axi_bvalid,
   input wire        nvm_rd_req,
   input wire [31:0] nvm_rd_addr,
   input wire        nvm_rd_ack,
   input wire [7:0]  req_node_address,
   input wire        node_address_match,
   input wire [7:0]  node_address,
   input wire        boot_window_open,
   input wire        user_start,
   input wire        user_mode,
   input wire [15:0] high_rate_baud,
   input wire        high_rate_boot_protocol,
   input wire [1:0]  slope_mode_field
);
   localparam [31:0] LO = `BNAC_FLASH_BASE + FLASH_SIZE - `BNAC_WIN_OFS;
   // One domain, reset quiets every check
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   bcast_match_a: assert property (
      node_address_match == (req_node_address == 8'hff || req_node_address == node_address))
      else $error("address match wrong");
   node_legal_a: assert property (node_address != 8'h00)
      else $error("zero node address in use");
   start_pulse_a: assert property (user_start |=> !user_start && user_mode)
      else $error("hand-over pulse wrong");
   user_hold_a: assert property (user_mode |=> user_mode && !boot_window_open)
      else $error("user mode left");
   slope_boot_a: assert property ($rose(high_rate_boot_protocol) |-> slope_mode_field == 2'h3)
      else $error("slope not set with high rate");
   baud_set_a: assert property ($rose(high_rate_boot_protocol) |-> ##[0:1] high_rate_baud == 16'h0480)
      else $error("high rate baud wrong");
   slope_keep_a: assert property (
      user_mode && $past(user_mode) && !$rose(s_axi_bvalid) |-> $stable(slope_mode_field))
      else $error("slope changed without write");
   node_keep_a: assert property (boot_window_open && $past(boot_window_open) |-> $stable(node_address))
      else $error("node address moved");
   fetch_hold_a: assert property (nvm_rd_req && !nvm_rd_ack |=> nvm_rd_req && $stable(nvm_rd_addr))
      else $error("flash request dropped");
   fetch_addr_a: assert property (nvm_rd_req |-> nvm_rd_addr >= LO && nvm_rd_addr <= LO + 32'h3)
      else $error("flash address out of range");
   fetch_done_a: assert property (user_mode |-> !nvm_rd_req)
      else $error("fetch after hand-over");
endmodule // bnac_boot_cfg_monitor

bind bnac_boot_cfg bnac_boot_cfg_monitor #(.FLASH_SIZE(FLASH_SIZE)) u_mon (.aclk(aclk), .aresetn(aresetn),
   .s_axi_bvalid(s_axi_bvalid), .nvm_rd_req(nvm_rd_req),
   .nvm_rd_addr(nvm_rd_addr), .nvm_rd_ack(nvm_rd_ack), .req_node_address(req_node_address),
   .node_address_match(node_address_match), .node_address(node_address), .boot_window_open(boot_window_open),
   .user_start(user_start), .user_mode(user_mode), .high_rate_baud(high_rate_baud),
   .high_rate_boot_protocol(high_rate_boot_protocol), .slope_mode_field(slope_mode_field));

// ==== bnac_flash_model.sv ====
/* Flash byte read model for the loader fetch port.
   Assumes four bytes from the window byte upward, delay set by slow. */
`timescale 1ns/1ps
`include "bnac_defines.vh"
module bnac_flash_model #(
   parameter [31:0] FLASH_SIZE = `BNAC_FLASH_SIZE_DEF
) (
   input  wire        aclk,
   input  wire [31:0] mem_bytes,
   input  wire [3:0]  slow,
   input  wire        nvm_rd_req,
   input  wire [31:0] nvm_rd_addr,
   output reg         nvm_rd_ack,
   output reg  [7:0]  nvm_rd_data
);
   reg  [3:0]  wait_q;
   wire [31:0] ofs = nvm_rd_addr - (`BNAC_FLASH_BASE + FLASH_SIZE - `BNAC_WIN_OFS);
   // Data toggles outside the ack cycle so a stale byte never looks valid
   always @(posedge aclk) begin
      nvm_rd_ack <= 1'h0;
      nvm_rd_data <= ~nvm_rd_data;
      if (!nvm_rd_req || nvm_rd_ack) begin
         wait_q <= 4'h0;
      end else if (wait_q == slow) begin
         nvm_rd_ack <= 1'h1;
         nvm_rd_data <= mem_bytes[8*ofs[1:0] +: 8];
      end else begin
         wait_q <= wait_q + 4'h1;
      end
   end
endmodule // bnac_flash_model

// ==== bnac_boot_cfg_test.sv ====
/* Self-checking bench for the boot configuration loader.
   Assumes the flash model, the checker bind and the defines header. */
`timescale 1ns/1ps
`include "bnac_defines.vh"
module bnac_boot_cfg_test;
   localparam integer STEP = 8;
   localparam integer NEVER = 150;
   reg         aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
   reg  [3:0]  s_axi_awaddr, s_axi_wstrb, s_axi_araddr, slow;
   reg  [31:0] s_axi_wdata, flash_bytes;
   reg  [7:0]  req_node_address;
   reg         boot_conn_open;
   wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire [1:0]  s_axi_bresp, s_axi_rresp, slope_mode_field;
   wire [31:0] s_axi_rdata, nvm_rd_addr;
   wire        nvm_rd_req, nvm_rd_ack, node_address_match, boot_window_open, user_start, user_mode;
   wire        boot_if_uart, high_rate_boot_protocol;
   wire [7:0]  nvm_rd_data, node_address;
   wire [15:0] high_rate_baud;
   integer     err_count;
   integer     checked;

   bnac_boot_cfg #(.STEP_CYC(STEP)) uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready), .nvm_rd_req(nvm_rd_req), .nvm_rd_addr(nvm_rd_addr),
      .nvm_rd_ack(nvm_rd_ack), .nvm_rd_data(nvm_rd_data), .req_node_address(req_node_address),
      .node_address_match(node_address_match), .boot_conn_open(boot_conn_open), .node_address(node_address),
      .boot_window_open(boot_window_open), .user_start(user_start), .user_mode(user_mode),
      .boot_if_uart(boot_if_uart), .high_rate_baud(high_rate_baud),
      .high_rate_boot_protocol(high_rate_boot_protocol), .slope_mode_field(slope_mode_field));

   bnac_flash_model u_flash (.aclk(aclk), .mem_bytes(flash_bytes), .slow(slow), .nvm_rd_req(nvm_rd_req),
      .nvm_rd_addr(nvm_rd_addr), .nvm_rd_ack(nvm_rd_ack), .nvm_rd_data(nvm_rd_data));

   // 4 ns clock
   initial begin
      aclk = 1'h0;
      forever #2 aclk = ~aclk;
   end

   task complete_run;
      begin
         $display("mismatches %0d, comparisons %0d", err_count, checked);
         if (err_count == 0 && checked > 0)
            $display("RESULT: PASS");
         else
            $display("RESULT: FAIL");
         $finish;
      end
   endtask

   task check(input [31:0] got, input [31:0] exp);
      begin
         checked = checked + 1;
         if (got !== exp) begin
            err_count = err_count + 1;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
         end
      end
   endtask

   // A used-up wait is a mismatch and ends the run
   task bound(input integer n, input integer lim);
      if (n >= lim) begin
         err_count = err_count + 1;
         $display("unexpected at %0t: wait ran out", $time);
         complete_run;
      end
   endtask

   // Each valid dropped when its own ready is sampled, response held for
   task axi_wr(input [3:0] a, input [31:0] d, input [1:0] r);
      integer n;
      begin
         s_axi_awaddr <= a;
         s_axi_wdata <= d;
         s_axi_awvalid <= 1'h1;
         s_axi_wvalid <= 1'h1;
         s_axi_bready <= 1'h1;
         n = 0;
         do begin
            @(posedge aclk);
            n = n + 1;
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
         end while (!s_axi_bvalid && n < 50);
         bound(n, 50);
         check(s_axi_bresp, r);
         s_axi_bready <= 1'h0;
         @(posedge aclk);
      end
   endtask

   task axi_rd(input [3:0] a, input [31:0] d, input [1:0] r);
      integer n;
      begin
         s_axi_araddr <= a;
         s_axi_arvalid <= 1'h1;
         s_axi_rready <= 1'h1;
         n = 0;
         do begin
            @(posedge aclk);
            n = n + 1;
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
         end while (!s_axi_rvalid && n < 50);
         bound(n, 50);
         check({s_axi_rresp, s_axi_rdata}, {r, d});
         s_axi_rready <= 1'h0;
         @(posedge aclk);
      end
   endtask

   task probe(input [7:0] r, input e);
      begin
         req_node_address <= r;
         @(posedge aclk);
         check(node_address_match, e);
      end
   endtask

   // Reset, boot from the given bytes, check setup and window length
   task run_case(input [31:0] b, input [3:0] s, input [7:0] nd, input u, input [1:0] hr, input integer cnt);
      integer n;
      begin
         flash_bytes <= b;
         slow <= s;
         aresetn <= 1'h0;
         repeat (12) @(posedge aclk);
         aresetn <= 1'h1;
         n = 0;
         do begin
            @(posedge aclk);
            n = n + 1;
         end while (!boot_window_open && !user_mode && n < 200);
         bound(n, 200);
         check(node_address, nd);
         check(boot_if_uart, u);
         if (hr != 2'h2) check({high_rate_baud, high_rate_boot_protocol, slope_mode_field}, hr[0] ? {16'h0480, 3'h7} : 19'h0);
         if (cnt != 0) begin
            n = 0;
            while (!user_start && n < NEVER) begin
               @(posedge aclk);
               n = n + 1;
            end
            check(n, cnt);
            @(posedge aclk);
         end
         check(user_mode, cnt != NEVER);
         probe(8'hff, 1'h1);
         probe(nd, 1'h1);
         probe(nd ^ 8'h01, 1'h0);
      end
   endtask

   // Main sequence: bytes are {addr_inv, addr, win_inv, win}
   initial begin
      err_count = 0;
      checked = 0;
      aresetn = 1'h0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, boot_conn_open} = 6'h0;
      {s_axi_awaddr, s_axi_araddr, slow} = 12'h0;
      s_axi_wstrb = 4'hf;
      s_axi_wdata = 32'h0;
      flash_bytes = 32'h0;
      req_node_address = 8'h00;
      @(posedge aclk);
      run_case(32'hfe01ba45, 4'h0, 8'h01, 1'h0, 2'h1, 4 * STEP);
      axi_rd(`BNAC_OFS_LINK_CTRL, 32'h00001801, `BNAC_RESP_OKAY);
      axi_wr(`BNAC_OFS_LINK_CTRL, 32'h00000000, `BNAC_RESP_OKAY);
      check(slope_mode_field, 2'h0);
      axi_rd(`BNAC_OFS_LINK_CTRL, 32'h00000000, `BNAC_RESP_OKAY);
      axi_wr(`BNAC_OFS_BOOT_STATUS, 32'h00000001, `BNAC_RESP_DECERR);
      axi_rd(4'hc, 32'h00000000, `BNAC_RESP_DECERR);
      run_case(32'hff00fe01, 4'h3, 8'h7f, 1'h0, 2'h0, 0);
      run_case(32'h00227d82, 4'h1, 8'h7f, 1'h1, 2'h1, STEP);
      run_case(32'hfe01f20d, 4'h0, 8'h01, 1'h0, 2'h0, NEVER);
      run_case(32'hffffffff, 4'h2, 8'h7f, 1'h0, 2'h0, NEVER);
      boot_conn_open <= 1'h1;
      @(posedge aclk);
      boot_conn_open <= 1'h0;
      repeat (2) @(posedge aclk);
      check({boot_window_open, user_mode}, 2'h0);
      complete_run;
   end
endmodule // bnac_boot_cfg_test
